// >>> src/name_id_codec.sv
`default_nettype none
module name_id_codec (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // build request
  input wire logic build_req,
  input wire name_id_pkg::name_format_t build_format,
  input wire logic [name_id_pkg::CID_W-1:0] build_company_id,
  input wire logic [name_id_pkg::LAN_EXT_W-1:0] build_lan_ext,
  input wire logic [name_id_pkg::VSID12_W-1:0] build_vendor_id12,
  input wire logic [name_id_pkg::VSID36_W-1:0] build_vendor_id36,
  input wire logic [name_id_pkg::NAME_W-1:0] build_id_extension,
  input wire logic [name_id_pkg::EUI_W-1:0] build_eui64,
  // build answer
  output logic build_done,
  output logic [name_id_pkg::LONG_NAME_W-1:0] name_out,
  output logic name_out_long,
  output logic build_fixed_up,
  // parse request, 8-byte names sit in the upper half
  input wire logic parse_req,
  input wire logic [name_id_pkg::LONG_NAME_W-1:0] name_in,
  // parse answer
  output logic parse_done,
  output var name_id_pkg::name_format_t parsed_format,
  output logic [3:0] parsed_code,
  output logic [name_id_pkg::CID_W-1:0] parsed_company_id,
  output logic [name_id_pkg::LAN_EXT_W-1:0] parsed_lan_ext,
  output logic [name_id_pkg::VSID36_W-1:0] parsed_vendor_id,
  output logic [name_id_pkg::NAME_W-1:0] parsed_id_extension,
  output logic [name_id_pkg::EUI_W-1:0] parsed_eui64,
  output logic parsed_long,
  output logic parsed_invalid
);
  import name_id_pkg::*;

  // ---------------------------------------------------------------
  // derived field positions
  // ---------------------------------------------------------------
  // every name but the eui mapped one opens with a four-bit code nibble
  localparam int CODE_W = $bits(CODE_IEEE48);
  localparam int BELOW_CODE = NAME_W - 1 - CODE_W;
  // eui mapped names spend only two bits on the code, so the fold starts higher
  localparam int FOLD_W = CID_FOLD_HI - CID_FOLD_LO + 1;
  localparam int FOLD_TOP = NAME_W - 1 - $bits(CODE_EUI_MAPPED_TOP);
  // the dropped ul/ig pair sits between the fold and the low company id bits
  localparam int DROP_W = CID_UL_BIT - CID_IG_BIT + 1;
  localparam int CID_LOW_W = CID_LOW_HI + 1;
  localparam int CID_LOW_TOP = FOLD_TOP - FOLD_W;
  // the vendor field of a mapped name keeps only what fits; the full
  // extension is reported through the id extension instead
  localparam int MAPPED_VID_W = VSID36_W - CODE_W;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // code recognition serves only the validity check; the format pick maps every unknown code to FMT_EUI_MAPPED
  function automatic logic code_known(input logic [3:0] code);
    code_known = (code == CODE_IEEE48) || (code == CODE_EXTENDED) ||
                 (code == CODE_REGISTERED) || (code == CODE_REG_EXTENDED) ||
                 (code[3:2] == CODE_EUI_MAPPED_TOP);
  endfunction : code_known

  function automatic name_format_t code_format(input logic [3:0] code);
    case (code)
      CODE_IEEE48: code_format = FMT_IEEE48;
      CODE_EXTENDED: code_format = FMT_EXTENDED;
      CODE_REGISTERED: code_format = FMT_REGISTERED;
      CODE_REG_EXTENDED: code_format = FMT_REG_EXTENDED;
      default: code_format = FMT_EUI_MAPPED;
    endcase
  endfunction : code_format

  // only the registered-extended layout spans sixteen bytes
  function automatic logic format_long(input name_format_t fmt);
    format_long = (fmt == FMT_REG_EXTENDED);
  endfunction : format_long

  // ---------------------------------------------------------------
  // field packers
  // ---------------------------------------------------------------
  logic [LAN_W-1:0] lan_field;
  logic lan_ul_ig_set;
  logic [NAME_W-1:0] eui_mapped;
  logic eui_ul_ig_set;

  lan_field_pack lan_pack (
    .company_id(build_company_id),
    .vendor_ext(build_lan_ext),
    .lan_field(lan_field),
    .ul_ig_set(lan_ul_ig_set)
  );

  eui64_mapper eui_map (
    .eui64(build_eui64),
    .mapped(eui_mapped),
    .ul_ig_set(eui_ul_ig_set)
  );

  // ---------------------------------------------------------------
  // build datapath
  // ---------------------------------------------------------------
  logic [NAME_W-1:0] reg_upper;
  logic [LONG_NAME_W-1:0] next_name;
  logic next_fixed_up;
  logic cid_ul_ig_set;

  assign cid_ul_ig_set = build_company_id[CID_UL_BIT] | build_company_id[CID_IG_BIT];

  // shared upper eight bytes of both registered layouts
  always_comb begin
    reg_upper = {CODE_REGISTERED, build_company_id, build_vendor_id36};
    reg_upper[NAME_REG_UL] = 1'b0;
    reg_upper[NAME_REG_IG] = 1'b0;
  end

  // eight-byte names are left aligned; the lower half then reads zero
  always_comb begin
    next_name = '0;
    next_fixed_up = 1'b0;
    case (build_format)
      FMT_IEEE48: begin
        next_name[LONG_NAME_W-1 -: NAME_W] =
          {CODE_IEEE48, CODE_ZERO_NIBBLE, CODE_ZERO_BYTE, lan_field};
        next_fixed_up = lan_ul_ig_set;
      end
      FMT_EXTENDED: begin
        next_name[LONG_NAME_W-1 -: NAME_W] =
          {CODE_EXTENDED, build_vendor_id12, lan_field};
        next_fixed_up = lan_ul_ig_set;
      end
      FMT_REGISTERED: begin
        next_name[LONG_NAME_W-1 -: NAME_W] = reg_upper;
        next_fixed_up = cid_ul_ig_set;
      end
      FMT_REG_EXTENDED: begin
        next_name[LONG_NAME_W-1 -: NAME_W] =
          {CODE_REG_EXTENDED, reg_upper[BELOW_CODE:0]};
        next_name[NAME_W-1:0] = build_id_extension;
        next_fixed_up = cid_ul_ig_set;
      end
      FMT_EUI_MAPPED: begin
        next_name[LONG_NAME_W-1 -: NAME_W] = eui_mapped;
        next_fixed_up = eui_ul_ig_set;
      end
      default: begin
        next_name = '0;
        next_fixed_up = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // build registers
  // ---------------------------------------------------------------
  // the name holds until the next build so a slow consumer can sample it
  // build_fixed_up tells the requester that ul/ig had to be cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      name_out <= '0;
      name_out_long <= 1'b0;
      build_fixed_up <= 1'b0;
    end else if (build_req) begin
      name_out <= next_name;
      name_out_long <= format_long(build_format);
      build_fixed_up <= next_fixed_up;
    end
  end

  // one-cycle strobe marking a fresh name
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      build_done <= 1'b0;
    end else begin
      build_done <= build_req;
    end
  end

  // ---------------------------------------------------------------
  // parse datapath
  // ---------------------------------------------------------------
  // the code is always read from the top nibble; the lower half matters only for 6h
  logic [NAME_W-1:0] upper;
  logic [CODE_W-1:0] in_code;
  name_format_t in_format;
  logic in_bad_bits;
  logic next_invalid;
  logic [CID_W-1:0] next_cid;
  logic [LAN_EXT_W-1:0] next_lan_ext;
  logic [VSID36_W-1:0] next_vendor;
  logic [NAME_W-1:0] next_id_ext;

  assign upper = name_in[LONG_NAME_W-1 -: NAME_W];
  assign in_code = upper[NAME_W-1 -: CODE_W];
  assign in_format = code_format(in_code);

  // fields are pulled out by layout; the eui mapped form refills 17/16 as zero
  always_comb begin
    next_cid = '0;
    next_lan_ext = '0;
    next_vendor = '0;
    next_id_ext = '0;
    in_bad_bits = 1'b0;
    case (in_format)
      FMT_IEEE48, FMT_EXTENDED: begin
        next_cid = upper[LAN_W-1 -: CID_W];
        next_lan_ext = upper[LAN_EXT_W-1:0];
        next_vendor = {{(VSID36_W-VSID12_W){1'b0}}, upper[BELOW_CODE -: VSID12_W]};
        in_bad_bits = upper[NAME_LAN_UL] | upper[NAME_LAN_IG];
        // the 48-bit layout also reserves byte 0 low nibble and byte 1
        if (in_format == FMT_IEEE48) begin
          in_bad_bits = in_bad_bits | (upper[BELOW_CODE -: VSID12_W] != '0);
        end
      end
      FMT_REGISTERED, FMT_REG_EXTENDED: begin
        next_cid = upper[BELOW_CODE -: CID_W];
        next_vendor = upper[VSID36_W-1:0];
        in_bad_bits = upper[NAME_REG_UL] | upper[NAME_REG_IG];
        if (in_format == FMT_REG_EXTENDED) begin
          next_id_ext = name_in[NAME_W-1:0];
        end
      end
      FMT_EUI_MAPPED: begin
        // the vendor field gets what fits; the whole extension rides in id_extension
        next_cid = {upper[FOLD_TOP -: FOLD_W], {DROP_W{1'b0}},
                    upper[CID_LOW_TOP -: CID_LOW_W]};
        next_vendor = {{(VSID36_W-MAPPED_VID_W){1'b0}}, upper[MAPPED_VID_W-1:0]};
        next_id_ext = {{(NAME_W-EUI_EXT_W){1'b0}}, upper[EUI_EXT_W-1:0]};
      end
      default: begin
        next_cid = '0;
      end
    endcase
  end

  // a bad name is still answered; the flag lets the consumer decide what to
  // do with it instead of stalling the parser
  assign next_invalid = !code_known(in_code) || in_bad_bits;

  // ---------------------------------------------------------------
  // parse registers
  // ---------------------------------------------------------------
  // results hold until the next parse request
  // a rejected name still has its fields pulled out for diagnosis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parsed_format <= FMT_IEEE48;
      parsed_code <= '0;
      parsed_company_id <= '0;
      parsed_lan_ext <= '0;
      parsed_vendor_id <= '0;
      parsed_id_extension <= '0;
      parsed_long <= 1'b0;
      parsed_invalid <= 1'b0;
    end else if (parse_req) begin
      parsed_format <= in_format;
      parsed_code <= in_code;
      parsed_company_id <= next_cid;
      parsed_lan_ext <= next_lan_ext;
      parsed_vendor_id <= next_vendor;
      parsed_id_extension <= next_id_ext;
      parsed_long <= format_long(in_format);
      parsed_invalid <= next_invalid;
    end
  end

  // eui-64 recovered from a mapped name; ul/ig come back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parsed_eui64 <= '0;
    end else if (parse_req) begin
      parsed_eui64 <= {next_cid, upper[EUI_EXT_W-1:0]};
    end
  end

  // one-cycle strobe marking fresh parse results
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parse_done <= 1'b0;
    end else begin
      parse_done <= parse_req;
    end
  end
endmodule : name_id_codec
`default_nettype wire

// >>> src/name_id_pkg.sv
`default_nettype none
package name_id_pkg;
  // ---------------------------------------------------------------
  // authority format codes (upper nibble of byte 0)
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_IEEE48 = 4'h1;
  localparam logic [3:0] CODE_EXTENDED = 4'h2;
  localparam logic [3:0] CODE_REGISTERED = 4'h5;
  localparam logic [3:0] CODE_REG_EXTENDED = 4'h6;
  localparam logic [1:0] CODE_EUI_MAPPED_TOP = 2'b11;
  localparam logic [3:0] CODE_ZERO_NIBBLE = 4'h0;
  localparam logic [7:0] CODE_ZERO_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam int CID_W = 24;
  localparam int LAN_EXT_W = 24;
  localparam int LAN_W = 48;
  localparam int EUI_W = 64;
  localparam int EUI_EXT_W = 40;
  localparam int VSID12_W = 12;
  localparam int VSID36_W = 36;
  localparam int NAME_W = 64;
  localparam int LONG_NAME_W = 128;

  // ---------------------------------------------------------------
  // bit positions
  // ---------------------------------------------------------------
  // universal/local and individual/group bits inside the company id
  localparam int CID_UL_BIT = 17;
  localparam int CID_IG_BIT = 16;
  // company id bits folded into byte 0 of the eui mapped name
  localparam int CID_FOLD_HI = 23;
  localparam int CID_FOLD_LO = 18;
  localparam int CID_LOW_HI = 15;
  // ul/ig position in a 64-bit name: byte 2 bits 1/0 (lan layouts)
  localparam int NAME_LAN_UL = 41;
  localparam int NAME_LAN_IG = 40;
  // ul/ig position in a 64-bit name: byte 1 bits 5/4 (registered layouts)
  localparam int NAME_REG_UL = 53;
  localparam int NAME_REG_IG = 52;

  // ---------------------------------------------------------------
  // name layouts
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_IEEE48,
    FMT_EXTENDED,
    FMT_REGISTERED,
    FMT_REG_EXTENDED,
    FMT_EUI_MAPPED
  } name_format_t;
endpackage : name_id_pkg
`default_nettype wire

// >>> src/name_fields.sv
`default_nettype none
// ---------------------------------------------------------------
// six-byte lan address field packer
// ---------------------------------------------------------------
module lan_field_pack (
  // company id and vendor extension
  input wire logic [name_id_pkg::CID_W-1:0] company_id,
  input wire logic [name_id_pkg::LAN_EXT_W-1:0] vendor_ext,
  // packed field and a flag for offending source bits
  output logic [name_id_pkg::LAN_W-1:0] lan_field,
  output logic ul_ig_set
);
  import name_id_pkg::*;
  // ul/ig are forced clear so the name is always a universal, individual one
  always_comb begin
    lan_field = {company_id, vendor_ext};
    lan_field[LAN_EXT_W + CID_UL_BIT] = 1'b0;
    lan_field[LAN_EXT_W + CID_IG_BIT] = 1'b0;
    ul_ig_set = company_id[CID_UL_BIT] | company_id[CID_IG_BIT];
  end
endmodule : lan_field_pack

// ---------------------------------------------------------------
// eui-64 to mapped name folding
// ---------------------------------------------------------------
module eui64_mapper (
  // source eui-64, company id in bytes 0..2
  input wire logic [name_id_pkg::EUI_W-1:0] eui64,
  // mapped name and a flag for offending source bits
  output logic [name_id_pkg::NAME_W-1:0] mapped,
  output logic ul_ig_set
);
  import name_id_pkg::*;
  logic [CID_W-1:0] cid;
  assign cid = eui64[EUI_W-1 -: CID_W];
  // bits 17/16 are simply never copied, so they cannot leak into the name
  assign mapped = {CODE_EUI_MAPPED_TOP,
                   cid[CID_FOLD_HI:CID_FOLD_LO],
                   cid[CID_LOW_HI:0],
                   eui64[EUI_EXT_W-1:0]};
  assign ul_ig_set = cid[CID_UL_BIT] | cid[CID_IG_BIT];
endmodule : eui64_mapper
`default_nettype wire

// >>> src/name_id_codec_end.sv
`default_nettype none
`default_nettype wire

// >>> bench/name_id_codec_sva.sv
`default_nettype none
module name_id_codec_chk
  import name_id_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // build side
  input wire logic build_req,
  input wire name_id_pkg::name_format_t build_format,
  input wire logic [11:0] build_vendor_id12,
  input wire logic [63:0] build_id_extension,
  input wire logic [63:0] build_eui64,
  input wire logic build_done,
  input wire logic [127:0] name_out,
  input wire logic name_out_long,
  // parse side
  input wire logic parse_req,
  input wire logic [127:0] name_in,
  input wire logic parsed_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // build and parse answers, all one cycle after the request
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_build_answer: assert property (build_done == $past(build_req))
    else $error("build answer late");
  chk_ieee48_head: assert property (build_req && build_format == FMT_IEEE48 |=>
    name_out[127:112] == 16'h1000 && !name_out_long) else $error("48-bit head wrong");
  chk_lan_ulig: assert property (build_req && build_format inside {FMT_IEEE48, FMT_EXTENDED}
    |=> name_out[105:104] == 2'b00) else $error("lan ul/ig set");
  chk_ext_head: assert property (build_req && build_format == FMT_EXTENDED |=>
    name_out[127:112] == {4'h2, $past(build_vendor_id12)}) else $error("extended head wrong");
  chk_reg_short: assert property (build_req && build_format == FMT_REGISTERED |=>
    name_out[127:124] == 4'h5 && name_out[63:0] == '0) else $error("registered wrong");
  chk_reg_ulig: assert property (build_req && build_format inside {FMT_REGISTERED,
    FMT_REG_EXTENDED} |=> name_out[117:116] == 2'b00) else $error("registered ul/ig set");
  chk_regext_long: assert property (build_req && build_format == FMT_REG_EXTENDED |=>
    name_out_long && name_out[63:0] == $past(build_id_extension)) else $error("long wrong");
  chk_eui_fold: assert property (build_req && build_format == FMT_EUI_MAPPED |=>
    name_out[127:120] == {2'b11, $past(build_eui64[63:58])}) else $error("eui fold wrong");
  chk_eui_body: assert property (build_req && build_format == FMT_EUI_MAPPED |=>
    name_out[119:64] == $past(build_eui64[55:0])) else $error("eui body wrong");
  chk_bad_code: assert property (parse_req && name_in[127:124] == 4'h3 |=>
    parsed_invalid) else $error("bad code accepted");
  cover property (build_req && build_format == FMT_EUI_MAPPED);
  cover property (build_req [*2]);
  cover property (parse_req ##1 parsed_invalid);
endmodule : name_id_codec_chk

bind name_id_codec name_id_codec_chk name_id_codec_chk_inst (.clk, .rst, .build_req,
  .build_format, .build_vendor_id12, .build_id_extension, .build_eui64, .build_done,
  .name_out, .name_out_long, .parse_req, .name_in, .parsed_invalid);
`default_nettype wire

// >>> bench/name_sink.sv
`default_nettype none
module name_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // names from the builder
  input wire logic build_done,
  input wire logic [127:0] name_out,
  // names forced in by the bench
  input wire logic inj,
  input wire logic [127:0] inj_name,
  // parser request
  output logic parse_req,
  output logic [127:0] name_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic echo_req;
  logic [127:0] echo_name;
  // every fresh name goes back into the parser unless inj forces a name in that cycle; idle bus toggles so no stale value passes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      echo_req <= 1'b0;
      echo_name <= '0;
    end else begin
      echo_req <= build_done;
      echo_name <= build_done ? name_out : ~echo_name;
    end
  end
  assign parse_req = inj | echo_req;
  assign name_in = inj ? inj_name : echo_name;
endmodule : name_sink
`default_nettype wire

// >>> bench/name_identifier_codec_tb.sv
`default_nettype none
module name_identifier_codec_tb;
  import name_id_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", w, e, g); end end
  logic clk, rst, build_req, build_done, name_out_long, build_fixed_up, parse_req;
  logic parse_done, parsed_long, parsed_invalid, inj;
  name_format_t build_format, parsed_format;
  logic [23:0] build_company_id, build_lan_ext, parsed_company_id, parsed_lan_ext;
  logic [11:0] build_vendor_id12;
  logic [35:0] build_vendor_id36, parsed_vendor_id;
  logic [63:0] build_id_extension, build_eui64, parsed_eui64, parsed_id_extension;
  logic [3:0] parsed_code;
  logic [147:0] xp;
  logic [127:0] name_out, name_in, inj_name;
  logic [31:0] seed = 32'h0000_9a0f;
  int err_count, checks_done, i;
  name_format_t fa [0:63];
  logic [127:0] na [0:63];
  logic [63:0] ea [0:63];
  logic fu [0:63];
  name_id_codec name_id_codec_inst (.clk, .rst, .build_req, .build_format, .build_company_id,
    .build_lan_ext, .build_vendor_id12, .build_vendor_id36, .build_id_extension, .build_eui64,
    .build_done, .name_out, .name_out_long, .build_fixed_up, .parse_req, .name_in, .parse_done,
    .parsed_format, .parsed_code, .parsed_company_id, .parsed_lan_ext,
    .parsed_vendor_id, .parsed_id_extension, .parsed_eui64, .parsed_long, .parsed_invalid);
  name_sink name_sink_inst (.clk, .rst, .build_done, .name_out, .inj, .inj_name, .parse_req,
    .name_in);
  // ------
  // reference model
  // ------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected name; ul/ig of the company id is cleared, not refused
  function automatic logic [127:0] ref_name(name_format_t f, logic [23:0] c, logic [23:0] x,
    logic [11:0] v, logic [35:0] w, logic [63:0] ix, logic [63:0] e);
    logic [23:0] m;
    m = c & 24'hfc_ffff;
    case (f)
      FMT_IEEE48: return {16'h1000, m, x, 64'h0};
      FMT_EXTENDED: return {4'h2, v, m, x, 64'h0};
      FMT_REGISTERED: return {4'h5, m, w, 64'h0};
      FMT_REG_EXTENDED: return {4'h6, m, w, ix};
      default: return {2'b11, e[63:58], e[55:0], 64'h0};
    endcase
  endfunction : ref_name
  // expected parse fields {company id, lan ext, vendor id, id extension} by layout
  function automatic logic [147:0] ref_fields(name_format_t f, logic [127:0] n);
    case (f)
      FMT_IEEE48, FMT_EXTENDED: return {n[111:88], n[87:64], 24'h0, n[123:112], 64'h0};
      FMT_REGISTERED: return {n[123:100], 24'h0, n[99:64], 64'h0};
      FMT_REG_EXTENDED: return {n[123:100], 24'h0, n[99:64], n[63:0]};
      default: return {n[125:120], 2'b00, n[119:104], 24'h0, 4'h0, n[95:64], 24'h0,
        n[103:64]};
    endcase
  endfunction : ref_fields
  function automatic logic code_ok(int c);
    return c == 1 || c == 2 || c == 5 || c == 6 || c >= 12;
  endfunction : code_ok
  // ------
  // run control
  // ------
  task report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // one name forced into the parser, answer read a cycle later
  task inject(input logic [127:0] n, input logic bad);
    inj = 1'b1;
    inj_name = n;
    @(posedge clk);
    #1;
    `CHK("parse_done", 1'b1, parse_done)
    `CHK("parsed_invalid", bad, parsed_invalid)
  endtask : inject
  // clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // watchdog, the run needs about 80 cycles
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  // back-to-back builds echoed through the parser, then forced names
  initial begin
    {rst, inj, build_req} = 3'b100;
    build_format = FMT_IEEE48;
    {build_company_id, build_lan_ext, build_vendor_id12, build_vendor_id36} = '0;
    {build_id_extension, build_eui64, inj_name} = '0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 44; i++) begin
      @(posedge clk);
      #1;
      if (i >= 1 && i <= 40) begin
        `CHK("build_done", 1'b1, build_done)
        `CHK("name_out", na[i-1], name_out)
        `CHK("name_out_long", fa[i-1] == FMT_REG_EXTENDED, name_out_long)
        `CHK("build_fixed_up", fu[i-1], build_fixed_up)
      end
      if (i == 41) `CHK("build_done", 1'b0, build_done)
      if (i >= 3 && i <= 42) begin
        `CHK("parse_done", 1'b1, parse_done)
        `CHK("parsed_invalid", 1'b0, parsed_invalid)
        `CHK("parsed_format", fa[i-3], parsed_format)
        xp = ref_fields(fa[i-3], na[i-3]);
        `CHK("parsed_code", na[i-3][127:124], parsed_code)
        `CHK("parsed_long", fa[i-3] == FMT_REG_EXTENDED, parsed_long)
        `CHK("parsed_company_id", xp[147:124], parsed_company_id)
        `CHK("parsed_lan_ext", xp[123:100], parsed_lan_ext)
        `CHK("parsed_vendor_id", xp[99:64], parsed_vendor_id)
        `CHK("parsed_id_extension", xp[63:0], parsed_id_extension)
        if (fa[i-3] == FMT_EUI_MAPPED)
          `CHK("parsed_eui64", ea[i-3] & 64'hfcff_ffff_ffff_ffff, parsed_eui64)
      end
      if (i < 40) begin
        build_format = name_format_t'(i < 5 ? i : rnd() % 5);
        build_company_id = i < 5 ? '1 : 24'(rnd());
        build_lan_ext = 24'(rnd());
        build_vendor_id12 = 12'(rnd());
        build_vendor_id36 = {rnd(), 4'(rnd())};
        build_id_extension = {rnd(), rnd()};
        build_eui64 = i < 5 ? '1 : {rnd(), rnd()};
        if (i >= 5 && i < 9) begin
          build_format = FMT_EUI_MAPPED;
          build_eui64[63:62] = 2'(i);
        end
        fa[i] = build_format;
        ea[i] = build_eui64;
        fu[i] = build_format == FMT_EUI_MAPPED ? |build_eui64[57:56] : |build_company_id[17:16];
        na[i] = ref_name(build_format, build_company_id, build_lan_ext, build_vendor_id12,
          build_vendor_id36, build_id_extension, build_eui64);
      end
      build_req = i < 40;
    end
    $display("test build and echo done");
    for (i = 0; i < 16; i++) inject({4'(i), 124'h0}, !code_ok(i));
    inject({4'h1, 124'h0} | (128'h1 << 104), 1'b1);
    inject({4'h1, 124'h0} | (128'h1 << 112), 1'b1);
    inject({4'h5, 124'h0} | (128'h1 << 117), 1'b1);
    inject({4'hc, 124'h0} | (128'h1 << 121), 1'b0);
    inj = 1'b0;
    $display("test forced names done");
    report_and_stop();
  end
endmodule : name_identifier_codec_tb
`default_nettype wire
